// file: cmd_pkg.sv
// Package with opcode layout, operation codes and exception classes of the major opcode decoder.
package cmd_pkg;
   // ************************************************************
   // Field layout
   // ************************************************************
   localparam int CMD_OP_HI = 15;
   localparam int CMD_OP_LO = 11;
   localparam int CMD_ROW_HI = 15;
   localparam int CMD_ROW_LO = 14;
   localparam int CMD_COL_HI = 13;
   localparam int CMD_COL_LO = 11;
   localparam int CMD_XBIT = 10;

   localparam logic [1:0] CMD_ROW_0 = 2'h0;
   localparam logic [1:0] CMD_ROW_1 = 2'h1;
   localparam logic [1:0] CMD_ROW_2 = 2'h2;
   localparam logic [1:0] CMD_ROW_3 = 2'h3;
   localparam logic [2:0] CMD_COL_JAL = 3'h3;
   localparam logic [2:0] CMD_COL_WIDE = 3'h7;
   localparam logic [2:0] CMD_COL_PREFIX = 3'h6;

   // ************************************************************
   // Operations and classes
   // ************************************************************
   typedef enum logic [5:0] {
      CMD_OP_NONE,
      CMD_OP_ADD_IMM_TO_STACK_PTR,
      CMD_OP_ADD_IMM_TO_PROG_COUNTER,
      CMD_OP_BRANCH,
      CMD_OP_JUMP_AND_LINK,
      CMD_OP_JUMP_LINK_EXCHANGE,
      CMD_OP_BRANCH_IF_ZERO,
      CMD_OP_BRANCH_IF_NONZERO,
      CMD_OP_SHIFT_CLASS,
      CMD_OP_LOAD_DOUBLEWORD,
      CMD_OP_REG_REG_IMM_ARITH_CLASS,
      CMD_OP_ADD_EIGHT_BIT_IMM,
      CMD_OP_SET_LESS_IMM,
      CMD_OP_SET_LESS_IMM_UNSIGNED,
      CMD_OP_EIGHT_BIT_IMM_CLASS,
      CMD_OP_LOAD_IMMEDIATE,
      CMD_OP_COMPARE_IMMEDIATE,
      CMD_OP_STORE_DOUBLEWORD,
      CMD_OP_LOAD_BYTE,
      CMD_OP_LOAD_HALFWORD,
      CMD_OP_LOAD_WORD_STACK_REL,
      CMD_OP_LOAD_WORD,
      CMD_OP_LOAD_BYTE_UNSIGNED,
      CMD_OP_LOAD_HALFWORD_UNSIGNED,
      CMD_OP_LOAD_WORD_PC_REL,
      CMD_OP_LOAD_WORD_UNSIGNED,
      CMD_OP_STORE_BYTE,
      CMD_OP_STORE_HALFWORD,
      CMD_OP_STORE_WORD_STACK_REL,
      CMD_OP_STORE_WORD,
      CMD_OP_THREE_REGISTER_CLASS,
      CMD_OP_TWO_REGISTER_CLASS,
      CMD_OP_PREFIX_CLASS,
      CMD_OP_WIDE_IMM_CLASS
   } cmd_op_e;

   typedef enum logic [2:0] {
      CMD_EXC_NONE,
      CMD_EXC_RESERVED,
      CMD_EXC_COP_UNUSABLE
   } cmd_exc_e;

   // Attribute marks attached to an encoding by the outer tables.
   typedef struct packed {
      logic reserved;
      logic higher_isa;
      logic wide_only;
      logic partner;
      logic debug_opt;
      logic ext_reserved;
      logic no_extend;
      logic is_cop;
   } cmd_mark_s;
endpackage

// file: cmd_decode_if.sv
// Interface carrying one decoded major opcode between the decode core and the top.
`timescale 1ns/1ps
interface cmd_decode_if;
   import cmd_pkg::*;
   logic [15:0] halfword;
   logic prefixed;
   cmd_op_e op;
   logic field_class;
   logic wide_only;
   logic no_extend;
   modport core (input halfword, input prefixed, output op, output field_class, output wide_only, output no_extend);
   modport user (output halfword, output prefixed, input op, input field_class, input wide_only, input no_extend);
endinterface

// file: cmd_major_table.sv
// Combinational major opcode table lookup.
`timescale 1ns/1ps
module cmd_major_table
   import cmd_pkg::*;
(
   cmd_decode_if.core dec
);
   logic [1:0] row;
   logic [2:0] col;

   // ************************************************************
   // Table lookup
   // ************************************************************
   // opcode field split.
   assign row = dec.halfword[CMD_ROW_HI:CMD_ROW_LO];
   assign col = dec.halfword[CMD_COL_HI:CMD_COL_LO];

   always_comb begin
      dec.op = CMD_OP_NONE;
      dec.field_class = 1'b0;
      // The last column of every row is the 64-bit gated one.
      dec.wide_only = (col == CMD_COL_WIDE);
      dec.no_extend = (row == CMD_ROW_3) && (col == CMD_COL_PREFIX);
      case (row)
         CMD_ROW_0: begin
            case (col)
               3'h0: dec.op = CMD_OP_ADD_IMM_TO_STACK_PTR;
               3'h1: dec.op = CMD_OP_ADD_IMM_TO_PROG_COUNTER;
               3'h2: dec.op = CMD_OP_BRANCH;
               3'h3: begin
                  dec.op = dec.halfword[CMD_XBIT] ? CMD_OP_JUMP_LINK_EXCHANGE : CMD_OP_JUMP_AND_LINK;
               end
               3'h4: dec.op = CMD_OP_BRANCH_IF_ZERO;
               3'h5: dec.op = CMD_OP_BRANCH_IF_NONZERO;
               3'h6: dec.op = CMD_OP_SHIFT_CLASS;
               default: dec.op = CMD_OP_LOAD_DOUBLEWORD;
            endcase
            dec.field_class = (col == CMD_COL_JAL) || (col == 3'h6);
         end
         CMD_ROW_1: begin
            case (col)
               3'h0: dec.op = CMD_OP_REG_REG_IMM_ARITH_CLASS;
               3'h1: dec.op = CMD_OP_ADD_EIGHT_BIT_IMM;
               3'h2: dec.op = CMD_OP_SET_LESS_IMM;
               3'h3: dec.op = CMD_OP_SET_LESS_IMM_UNSIGNED;
               3'h4: dec.op = CMD_OP_EIGHT_BIT_IMM_CLASS;
               3'h5: dec.op = CMD_OP_LOAD_IMMEDIATE;
               3'h6: dec.op = CMD_OP_COMPARE_IMMEDIATE;
               default: dec.op = CMD_OP_STORE_DOUBLEWORD;
            endcase
            dec.field_class = (col == 3'h0) || (col == 3'h4);
         end
         CMD_ROW_2: begin
            case (col)
               3'h0: dec.op = CMD_OP_LOAD_BYTE;
               3'h1: dec.op = CMD_OP_LOAD_HALFWORD;
               3'h2: dec.op = CMD_OP_LOAD_WORD_STACK_REL;
               3'h3: dec.op = CMD_OP_LOAD_WORD;
               3'h4: dec.op = CMD_OP_LOAD_BYTE_UNSIGNED;
               3'h5: dec.op = CMD_OP_LOAD_HALFWORD_UNSIGNED;
               3'h6: dec.op = CMD_OP_LOAD_WORD_PC_REL;
               default: dec.op = CMD_OP_LOAD_WORD_UNSIGNED;
            endcase
         end
         default: begin
            case (col)
               3'h0: dec.op = CMD_OP_STORE_BYTE;
               3'h1: dec.op = CMD_OP_STORE_HALFWORD;
               3'h2: dec.op = CMD_OP_STORE_WORD_STACK_REL;
               3'h3: dec.op = CMD_OP_STORE_WORD;
               3'h4: dec.op = CMD_OP_THREE_REGISTER_CLASS;
               3'h5: dec.op = CMD_OP_TWO_REGISTER_CLASS;
               3'h6: dec.op = CMD_OP_PREFIX_CLASS;
               default: dec.op = CMD_OP_WIDE_IMM_CLASS;
            endcase
            dec.field_class = (col >= 3'h4);
         end
      endcase
   end
endmodule

// file: cmd_major_decoder.sv
// Major opcode decoder with exception classification for 16-bit compressed instructions.
// ************************************************************
// ************************************************************
`timescale 1ns/1ps
module cmd_major_decoder
   import cmd_pkg::*;
#(
   parameter bit DEBUG_ENC_IMPL = 1'b0,
   parameter bit EXT_IMPL = 1'b1
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [15:0] halfword,
   input wire logic halfword_valid,
   input wire logic prefixed,
   input wire logic kernel_mode,
   input wire logic debug_mode,
   input wire logic wide_enabled,
   input wire logic is_cop,
   input wire logic cop_usable,
   input wire logic mark_reserved,
   input wire logic mark_higher_isa,
   input wire logic mark_partner,
   input wire logic partner_assigned,
   input wire logic mark_debug,
   input wire logic debug_match,
   input wire logic mark_ext,
   output cmd_op_e op_ff,
   output logic field_class_ff,
   output cmd_exc_e exc_ff,
   output logic valid_ff
);
   cmd_decode_if dec ();
   cmd_exc_e exc_comb;
   cmd_op_e nxt_op;
   logic nxt_field_class;
   cmd_exc_e nxt_exc;
   logic nxt_valid;

   assign dec.halfword = halfword;
   assign dec.prefixed = prefixed;

   cmd_major_table u_table (
      .dec(dec)
   );

   // Picks reserved or coprocessor-unusable by coprocessor access.
   function automatic cmd_exc_e cop_split(input logic cop, input logic usable);
      cop_split = (cop && !usable) ? CMD_EXC_COP_UNUSABLE : CMD_EXC_RESERVED;
   endfunction

   // ************************************************************
   // Exception classification
   // ************************************************************
   always_comb begin
      exc_comb = CMD_EXC_NONE;
      if (mark_reserved) begin
         exc_comb = CMD_EXC_RESERVED;
      end else if (mark_higher_isa) begin
         exc_comb = CMD_EXC_RESERVED;
      // omitted debug encoding; implemented one must match its pattern.
      end else if (mark_debug && (!DEBUG_ENC_IMPL || !debug_match)) begin
         exc_comb = CMD_EXC_RESERVED;
      end else if (mark_ext && !EXT_IMPL) begin
         exc_comb = CMD_EXC_RESERVED;
      end else if (mark_partner && !partner_assigned) begin
         exc_comb = cop_split(is_cop, cop_usable);
      end else if (prefixed && dec.no_extend) begin
         exc_comb = CMD_EXC_RESERVED;
      end else if (dec.wide_only && !(kernel_mode || debug_mode || wide_enabled)) begin
         exc_comb = cop_split(is_cop, cop_usable);
      end
   end

   // ************************************************************
   // Output stage
   // ************************************************************
   always_comb begin
      // same-cycle decode, captured for a flopped view.
      nxt_valid = halfword_valid;
      nxt_op = halfword_valid ? dec.op : CMD_OP_NONE;
      nxt_field_class = halfword_valid && dec.field_class;
      nxt_exc = halfword_valid ? exc_comb : CMD_EXC_NONE;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         op_ff <= CMD_OP_NONE;
         field_class_ff <= 1'b0;
         exc_ff <= CMD_EXC_NONE;
         valid_ff <= 1'b0;
      end else begin
         op_ff <= nxt_op;
         field_class_ff <= nxt_field_class;
         exc_ff <= nxt_exc;
         valid_ff <= nxt_valid;
      end
   end
endmodule

// file: cmd_fetch_model.sv
// Fetch stage model that hands one decode request to the decoder per cycle.
`timescale 1ns/1ps
module cmd_fetch_model (
   input wire logic clk_sys,
   output logic [29:0] req_ff
);
   // Requests move on the falling edge, so the decoder always samples settled levels.
   initial req_ff = 30'h0;
   task automatic send(input logic [29:0] v);
      @(negedge clk_sys);
      req_ff <= v;
   endtask
endmodule

// file: cmd_major_decoder_chk.sv
// Checker of the major opcode decoder ports.
`timescale 1ns/1ps
module cmd_major_decoder_chk
   import cmd_pkg::*;
#(
   parameter bit DEBUG_ENC_IMPL = 1'b0,
   parameter bit EXT_IMPL = 1'b1
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [15:0] halfword,
   input wire logic halfword_valid, prefixed, kernel_mode, debug_mode, wide_enabled, is_cop, cop_usable,
   input wire logic mark_reserved, mark_higher_isa, mark_partner, partner_assigned, mark_debug, mark_ext,
   input wire logic debug_match,
   input cmd_op_e op_ff,
   input wire logic field_class_ff,
   input cmd_exc_e exc_ff,
   input wire logic valid_ff
);
   logic [4:0] opc;
   logic nomk;
   logic cu;
   assign opc = halfword[15:11];
   assign nomk = !(mark_reserved | mark_higher_isa | mark_debug | mark_partner | mark_ext);
   assign cu = is_cop && !cop_usable;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   valid_lag_a: assert property (halfword_valid |=> valid_ff) else $error("valid_ff missing");
   idle_none_a: assert property (!halfword_valid |=> !valid_ff && op_ff == CMD_OP_NONE && exc_ff == CMD_EXC_NONE)
      else $error("idle output not empty");
   link_plain_a: assert property (halfword_valid && opc == 5'h03 && !halfword[10]
      |=> op_ff == CMD_OP_JUMP_AND_LINK && field_class_ff) else $error("plain link wrong");
   link_exch_a: assert property (halfword_valid && opc == 5'h03 && halfword[10]
      |=> op_ff == CMD_OP_JUMP_LINK_EXCHANGE && field_class_ff) else $error("exchange link wrong");
   resv_exc_a: assert property (halfword_valid && mark_reserved |=> exc_ff == CMD_EXC_RESERVED)
      else $error("reserved not raised");
   isa_exc_a: assert property (halfword_valid && mark_higher_isa |=> exc_ff == CMD_EXC_RESERVED)
      else $error("higher level not raised");
   // An omitted debug encoding always traps; an implemented one traps off its own pattern.
   dbg_exc_a: assert property (halfword_valid && mark_debug && (!DEBUG_ENC_IMPL || !debug_match)
      |=> exc_ff == CMD_EXC_RESERVED) else $error("debug code not raised");
   // implemented debug encoding at its pattern passes.
   dbg_pass_a: assert property (halfword_valid && DEBUG_ENC_IMPL && mark_debug && debug_match && !prefixed
      && !(mark_reserved || mark_higher_isa || mark_partner || mark_ext) && opc[2:0] != 3'h7
      |=> exc_ff == CMD_EXC_NONE) else $error("debug code wrongly raised");
   ext_exc_a: assert property (halfword_valid && mark_ext && !EXT_IMPL |=> exc_ff == CMD_EXC_RESERVED)
      else $error("extension code not raised");
   wide_pass_a: assert property (halfword_valid && nomk && opc[2:0] == 3'h7 && (kernel_mode || debug_mode
      || wide_enabled) |=> exc_ff == CMD_EXC_NONE) else $error("wide op blocked");
   wide_gate_a: assert property (halfword_valid && nomk && opc[2:0] == 3'h7 && !(kernel_mode || debug_mode
      || wide_enabled) |=> exc_ff == ($past(cu) ? CMD_EXC_COP_UNUSABLE : CMD_EXC_RESERVED))
      else $error("wide op not gated");
   prefix_exc_a: assert property (halfword_valid && nomk && opc == 5'h1e && prefixed
      |=> exc_ff == CMD_EXC_RESERVED) else $error("prefixed class not raised");
   partner_exc_a: assert property (halfword_valid && mark_partner && !partner_assigned && !(mark_reserved
      || mark_higher_isa || mark_debug || (mark_ext && !EXT_IMPL))
      |=> exc_ff == ($past(cu) ? CMD_EXC_COP_UNUSABLE : CMD_EXC_RESERVED))
      else $error("empty partner code not raised");
endmodule
bind cmd_major_decoder cmd_major_decoder_chk #(.DEBUG_ENC_IMPL(DEBUG_ENC_IMPL), .EXT_IMPL(EXT_IMPL)) i_chk (
   .clk_sys, .rst_n, .halfword, .halfword_valid, .prefixed, .debug_match,
   .kernel_mode, .debug_mode, .wide_enabled, .is_cop, .cop_usable, .mark_reserved, .mark_higher_isa,
   .mark_partner, .partner_assigned, .mark_debug, .mark_ext, .op_ff, .field_class_ff, .exc_ff, .valid_ff);

// file: tb.sv
// Self-checking bench of the major opcode decoder.
`timescale 1ns/1ps
module tb;
   import cmd_pkg::*;
   localparam logic [31:0] CLS = 32'hf000_1148;
   localparam bit DEF_DBG = 1'b0;
   localparam bit DEF_EXT = 1'b1;
   localparam bit ALT_DBG = 1'b1;
   localparam bit ALT_EXT = 1'b0;
   logic clk_sys;
   logic rst_n;
   logic [29:0] req;
   logic [29:0] v;
   cmd_op_e op_ff;
   logic field_class_ff;
   cmd_exc_e exc_ff;
   logic valid_ff;
   cmd_op_e alt_op;
   logic alt_fc;
   cmd_exc_e alt_exc;
   logic alt_valid;
   logic [12:0] q[$];
   logic [12:0] e;
   int fails;
   int checks;
   int seed;
   int r;
   int m;
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   cmd_fetch_model i_fetch (.clk_sys(clk_sys), .req_ff(req));
   cmd_major_decoder i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .halfword(req[29:14]), .halfword_valid(req[13]),
      .prefixed(req[12]), .kernel_mode(req[11]), .debug_mode(req[10]), .wide_enabled(req[9]), .is_cop(req[8]),
      .cop_usable(req[7]), .mark_reserved(req[6]), .mark_higher_isa(req[5]), .mark_partner(req[4]),
      .partner_assigned(req[3]), .mark_debug(req[2]), .debug_match(req[1]), .mark_ext(req[0]), .op_ff(op_ff),
      .field_class_ff(field_class_ff), .exc_ff(exc_ff), .valid_ff(valid_ff));
   // A second build with the debug encoding present and the extension absent, so both options are exercised.
   cmd_major_decoder #(.DEBUG_ENC_IMPL(ALT_DBG), .EXT_IMPL(ALT_EXT)) i_dut_alt (.clk_sys(clk_sys), .rst_n(rst_n),
      .halfword(req[29:14]), .halfword_valid(req[13]), .prefixed(req[12]), .kernel_mode(req[11]),
      .debug_mode(req[10]), .wide_enabled(req[9]), .is_cop(req[8]), .cop_usable(req[7]), .mark_reserved(req[6]),
      .mark_higher_isa(req[5]), .mark_partner(req[4]), .partner_assigned(req[3]), .mark_debug(req[2]),
      .debug_match(req[1]), .mark_ext(req[0]), .op_ff(alt_op), .field_class_ff(alt_fc), .exc_ff(alt_exc),
      .valid_ff(alt_valid));
   // Expected exception from the exception order chosen for this block, for one build.
   function automatic cmd_exc_e exc_of(input logic [29:0] x, input logic dbg_impl, input logic ext_impl);
      logic cu;
      logic [4:0] o;
      cu = x[8] && !x[7];
      o = x[29:25];
      if (x[6] || x[5] || (x[2] && (!dbg_impl || !x[1])) || (x[0] && !ext_impl)) begin
         return CMD_EXC_RESERVED;
      end else if (x[4] && !x[3]) begin
         return cu ? CMD_EXC_COP_UNUSABLE : CMD_EXC_RESERVED;
      end else if (o == 5'h1e && x[12]) begin
         return CMD_EXC_RESERVED;
      end else if (o[2:0] == 3'h7 && !(x[11] || x[10] || x[9])) begin
         return cu ? CMD_EXC_COP_UNUSABLE : CMD_EXC_RESERVED;
      end
      return CMD_EXC_NONE;
   endfunction
   // Expected result from the opcode table, with the exceptions of both builds.
   function automatic logic [12:0] exp_of(input logic [29:0] x);
      logic [4:0] o;
      cmd_op_e op;
      o = x[29:25];
      op = cmd_op_e'(o < 3 ? o + 1 : (o > 3 ? o + 2 : 4 + x[24]));
      return {op, CLS[o], exc_of(x, DEF_DBG, DEF_EXT), exc_of(x, ALT_DBG, ALT_EXT)};
   endfunction
   task automatic drive(input logic [29:0] x);
      i_fetch.send(x);
      if (x[13]) q.push_back(exp_of(x));
   endtask
   task automatic final_report;
      if (fails == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(negedge clk_sys) begin
      if (valid_ff === 1'b1) begin
         e = (q.size() > 0) ? q.pop_front() : 13'hx;
         checks++;
         if ({op_ff, field_class_ff, exc_ff, alt_exc} !== e) begin
            fails++;
            $display("unexpected decode expected %h seen %h", e, {op_ff, field_class_ff, exc_ff, alt_exc});
         end
         if ({alt_valid, alt_op, alt_fc} !== {1'b1, e[12:6]}) begin
            fails++;
            $display("unexpected alt_decode expected %h seen %h", {1'b1, e[12:6]}, {alt_valid, alt_op, alt_fc});
         end
      end
   end
   initial begin
      repeat (2000) @(posedge clk_sys);
      fails++;
      final_report();
   end
   initial begin
      fails = 0;
      checks = 0;
      seed = 5;
      rst_n = 1'b0;
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      // Every opcode and link bit, back to back, with and without prefix and kernel mode.
      for (int i = 0; i < 128; i++) begin
         drive({5'(i), i[5], 10'h2a5 ^ 10'(i), 1'b1, i[6], i[6], 11'h0});
      end
      // Sparse marks keep the lower priority exception paths reachable.
      for (int i = 0; i < 400; i++) begin
         r = $random(seed);
         m = $random(seed) & $random(seed);
         v = {r[31:16], |r[1:0], r[7:2], 7'(m) & r[14:8]};
         drive(v);
      end
      drive(30'h0);
      repeat (3) @(negedge clk_sys);
      checks++;
      if (q.size() != 0) begin
         fails++;
         $display("unexpected pending expected 0 seen %0d", q.size());
      end
      final_report();
   end
endmodule
